// ==== hdl/card_reader_control_regs.sv ====
// Summary of operation
// [R1] Queue occupancy zero to eight at control 27:24
// [R2] Card timeout enable gates card timeout interrupt
// [R3] Aux sample enable gates aux sample interrupt
// [R4] Underflow and overflow interrupts gated by enables
// [R5] Level enable raises interrupt at queue level
// [R6] Per-track timeout enables gate own track
// [R7] Bypass bit write-only, selects digital inputs
// [R8] Per-track mode: raw sampling or peak detection
// [R9] Writing one soft-resets state machines and queue
// [R10] Shared floor mode static or scaled previous peak
// [R11] DMA request when occupancy reaches queue level
// [R12] Queue level field means value plus one
// [R13] Per-track enable bits in control 2:0
// [R14] Card timeout when last active track times out
// [R15] Aux sample flag; flags cleared by writing one
// [R16] Latch underflow and overflow flags
// [R17] Level flag when occupancy reaches level
// [R18] Per-track timeout flags at bits 18:16
// [R19] Status bit 0 mirrors interrupt output
// [R20] Track times out when counter reaches limit
// [R21] Flags set regardless of enable; any enabled flag interrupts
// [R22] Timeout stores entry, stops timer until next crossing
// [R23] Scaled floor never below programmed floor, reset on timeout
// [R24] Writing zero keeps flags; reserved bits read zero
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "card_reader_params.svh"
module card_reader_control_regs
  import card_reader_pkg::*;
#(
  parameter int TRACKS = 3,
  parameter int TW = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [TRACKS-1:0] sample_tick,
  input wire logic [TRACKS-1:0] peak_crossing,
  input wire logic [TRACKS*TW-1:0] peak_amplitude,
  input wire logic queue_push,
  input wire logic queue_pop,
  input wire logic aux_sample_new,
  output logic [TRACKS-1:0] track_on,
  output logic [TRACKS-1:0] track_raw_sampling_select,
  output logic converter_bypass,
  output logic [TRACKS-1:0] timeout_store,
  output logic [TRACKS*TW-1:0] track_floor_scaled,
  output logic [TRACKS-1:0] floor_restore,
  output logic datapath_reset,
  output logic [3:0] queue_count,
  output logic dma_request,
  output logic irq
);
  logic [31:0] ctl_ff;
  logic bypass_ff;
  logic [7:0] flags_ff;
  logic [TW-1:0] limit_ff;
  logic [3:0] count_ff;
  logic soft_ff;
  logic aw_ff, w_ff, bvalid_ff, rvalid_ff, irq_ff, dma_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [TRACKS-1:0] to_event;
  logic [TRACKS-1:0] started;
  logic [TRACKS-1:0] timed_out;
  logic [3:0] level;
  logic level_hit;
  logic card_event;
  logic queue_underrun_flag_event, queue_overrun_flag_event;
  logic do_write;
  logic [31:0] wmask;
  logic [7:0] flag_clr, flag_set, irq_en;

  assign level = {1'b0, ctl_ff[`CTL_LVL_LSB +: 3]} + 4'h1; // R12
  assign level_hit = count_ff >= level;
  assign do_write = aw_ff && w_ff && !bvalid_ff;
  assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

  // AXI write address and data capture
  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        aw_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        w_ff <= 1'b0;
      end
    end
  end

  // Write response; unmapped writes answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (awaddr_ff[11:2] <= 10'h002) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Control register, bypass and soft reset pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_ff <= `RST_CONTROL;
      bypass_ff <= 1'b0;
      soft_ff <= 1'b0;
    end else begin
      soft_ff <= 1'b0;
      if (do_write && awaddr_ff[11:2] == 10'(`OFS_READER_CONTROL >> 2)) begin
        ctl_ff <= (ctl_ff & ~(wmask & `CTL_RW_MASK)) | (wdata_ff & wmask & `CTL_RW_MASK);
        if (wstrb_ff[1]) begin
          bypass_ff <= wdata_ff[`CTL_BYPASS]; // R7
          soft_ff <= wdata_ff[`CTL_SOFT]; // R9
        end
      end
    end
  end

  // Timeout limit register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_ff <= `RST_TIMEOUT_LIMIT;
    end else if (do_write && awaddr_ff[11:2] == 10'(`OFS_READER_TIMEOUT_LIMIT >> 2)) begin
      if (wstrb_ff[0]) limit_ff[7:0] <= wdata_ff[7:0];
      if (wstrb_ff[1]) limit_ff[11:8] <= wdata_ff[11:8];
    end
  end

  // Queue occupancy tracking, saturating at depth
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_ff) begin
      count_ff <= 4'h0; // R9
    end else if (queue_push && !queue_pop && count_ff != 4'(`QUEUE_DEPTH)) begin
      count_ff <= count_ff + 4'h1; // R1
    end else if (queue_pop && !queue_push && count_ff != 4'h0) begin
      count_ff <= count_ff - 4'h1;
    end
  end
  assign queue_underrun_flag_event = queue_pop && !queue_push && count_ff == 4'h0;
  assign queue_overrun_flag_event = queue_push && !queue_pop && count_ff == 4'(`QUEUE_DEPTH);

  // Per-track timers
  genvar t;
  generate
    for (t = 0; t < TRACKS; t++) begin : g_trk
      trk_state_t st_ff;
      logic [TW-1:0] cnt_ff;
      logic [TW-1:0] peak_ff;
      logic [TW-1:0] scaled;
      logic [TW-1:0] amp;
      assign amp = peak_amplitude[t*TW +: TW];
      always_ff @(posedge aclk) begin
        if (!aresetn || soft_ff || !ctl_ff[`CTL_ON_LSB + t]) begin // R13 R9
          st_ff <= trk_idle;
          cnt_ff <= '0;
        end else begin
          case (st_ff)
            trk_idle: if (peak_crossing[t]) st_ff <= trk_count;
            trk_count: begin
              if (peak_crossing[t]) begin
                cnt_ff <= '0;
              end else if (sample_tick[t]) begin
                if (cnt_ff + 12'h001 >= limit_ff) st_ff <= trk_timed_out; // R20
                cnt_ff <= cnt_ff + 12'h001;
              end
            end
            trk_timed_out: begin
              if (peak_crossing[t]) begin // R22
                st_ff <= trk_count;
                cnt_ff <= '0;
              end
            end
            default: st_ff <= trk_idle;
          endcase
        end
      end
      assign to_event[t] = st_ff == trk_count && !peak_crossing[t] && sample_tick[t]
                           && cnt_ff + 12'h001 >= limit_ff;
      assign started[t] = st_ff != trk_idle;
      assign timed_out[t] = st_ff == trk_timed_out;
      // Previous peak for scaled floor; cleared on timeout
      always_ff @(posedge aclk) begin
        if (!aresetn || soft_ff || to_event[t]) begin
          peak_ff <= '0; // R23
        end else if (peak_crossing[t]) begin
          peak_ff <= amp;
        end
      end
      always_comb begin
        case (floor_mode_t'(ctl_ff[`CTL_THR_LSB +: 2])) // R10
          floor_quarter: scaled = peak_ff >> 2;
          floor_eighth: scaled = peak_ff >> 3;
          floor_sixteenth: scaled = peak_ff >> 4;
          default: scaled = '0;
        endcase
      end
      // Datapath takes the larger of this and its programmed floor
      assign track_floor_scaled[t*TW +: TW] = scaled; // R23
    end
  endgenerate
  assign timeout_store = to_event; // R22
  assign floor_restore = to_event; // R23

  // Card timeout: a timing-out track with all others finished or idle
  always_comb begin
    logic others_done;
    others_done = 1'b1;
    card_event = 1'b0;
    for (int i = 0; i < TRACKS; i++) begin
      if (to_event[i]) begin
        others_done = 1'b1;
        for (int j = 0; j < TRACKS; j++) begin
          if (j != i && started[j] && !timed_out[j] && !to_event[j]) others_done = 1'b0;
        end
        if (others_done) card_event = 1'b1; // R14
      end
    end
  end

  // Event flags: set wins over write-one clear
  assign flag_clr = (do_write && awaddr_ff[11:2] == 10'(`OFS_READER_IRQ_STATUS >> 2) && wstrb_ff[2])
                    ? wdata_ff[23:16] : 8'h00; // R15 R24
  assign flag_set = {card_event, aux_sample_new, queue_underrun_flag_event, queue_overrun_flag_event, level_hit,
                     to_event}; // R14 R15 R16 R17 R18 R21
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= 8'h00;
    end else begin
      flags_ff <= (flags_ff & ~flag_clr) | flag_set; // R21
    end
  end

  // Interrupt and DMA request
  assign irq_en = ctl_ff[23:16]; // R2 R3 R4 R5 R6
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
      dma_ff <= 1'b0;
    end else begin
      irq_ff <= |(flags_ff & irq_en); // R21
      dma_ff <= ctl_ff[`CTL_DMA] && level_hit; // R11
    end
  end

  // Read channel
  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= 2'h0;
      case (s_axi_araddr[11:2])
        10'h000: rdata_ff <= (ctl_ff & `CTL_RW_MASK) | {4'h0, count_ff, 24'h000000}; // R1 R7
        10'h001: rdata_ff <= {8'h00, flags_ff, 15'h0000, irq_ff}; // R19 R24
        10'h002: rdata_ff <= {20'h00000, limit_ff};
        default: begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  assign track_on = ctl_ff[`CTL_ON_LSB +: 3];
  assign track_raw_sampling_select = ctl_ff[`CTL_MODE_LSB +: 3]; // R8
  assign converter_bypass = bypass_ff;
  assign datapath_reset = soft_ff;
  assign queue_count = count_ff;
  assign dma_request = dma_ff;
  assign irq = irq_ff;
endmodule // card_reader_control_regs
`default_nettype wire

// ==== common/card_reader_params.svh ====
`ifndef CARD_READER_PARAMS_SVH
`define CARD_READER_PARAMS_SVH
// Register byte offsets
`define OFS_READER_CONTROL 12'h000
`define OFS_READER_IRQ_STATUS 12'h004
`define OFS_READER_TIMEOUT_LIMIT 12'h008
`define OFS_READER_SAMPLE_QUEUE 12'h00c
`define OFS_READER_CONVERTER_SETUP 12'h010
`define OFS_TRACK_DC_OFFSET 12'h014
`define OFS_TRACK_PEAK_FLOOR 12'h020
`define OFS_READER_AUX_SAMPLE 12'h02c
// Control field positions
`define CTL_COUNT_LSB 24
`define CTL_CARD_TIMEOUT_IRQ_ENABLE 23
`define CTL_AUX_IEN 22
`define CTL_QUEUE_UNDERRUN_IRQ_ENABLE 21
`define CTL_QUEUE_OVERRUN_IRQ_ENABLE 20
`define CTL_QUEUE_LEVEL_IRQ_ENABLE 19
`define CTL_TO_IEN_LSB 16
`define CTL_BYPASS 15
`define CTL_MODE_LSB 10
`define CTL_SOFT 9
`define CTL_THR_LSB 7
`define CTL_DMA 6
`define CTL_LVL_LSB 3
`define CTL_ON_LSB 0
// Status field positions
`define ST_CARD_TIMEOUT_FLAG 23
`define ST_AUX 22
`define ST_QUEUE_UNDERRUN_FLAG 21
`define ST_QUEUE_OVERRUN_FLAG 20
`define ST_LVL 19
`define ST_TO_LSB 16
`define ST_IRQ 0
// Control writable mask (bits 23:16, 12:10, 8:0)
`define CTL_RW_MASK 32'h00ff1dff
// Reset values
`define RST_CONTROL 32'h00000000
`define RST_TIMEOUT_LIMIT 12'hfff
`define QUEUE_DEPTH 8
`endif

// ==== common/card_reader_pkg.sv ====
package card_reader_pkg;
  // Peak floor scaling modes
  typedef enum logic [1:0] {
    floor_static = 2'h0,
    floor_quarter = 2'h1,
    floor_eighth = 2'h2,
    floor_sixteenth = 2'h3
  } floor_mode_t;
  // Per-track timer states
  typedef enum logic [2:0] {
    trk_idle = 3'h1,
    trk_count = 3'h2,
    trk_timed_out = 3'h4
  } trk_state_t;
endpackage

// ==== test/card_reader_control_regs_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module card_reader_control_regs_sva #(
  parameter int TRACKS = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [TRACKS-1:0] sample_tick,
  input wire logic [TRACKS-1:0] peak_crossing,
  input wire logic [TRACKS-1:0] track_on,
  input wire logic [TRACKS-1:0] timeout_store,
  input wire logic [TRACKS-1:0] floor_restore,
  input wire logic queue_push,
  input wire logic queue_pop,
  input wire logic datapath_reset,
  input wire logic [3:0] queue_count,
  input wire logic dma_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Queue count bounds and steps
  AST_CNT_MAX: assert property (queue_count <= 4'h8) else $error("count over 8");
  AST_CNT_UP: assert property (queue_push && !queue_pop && queue_count < 4'h8 |=>
    queue_count == $past(queue_count) + 4'h1) else $error("push lost");
  AST_OVR_HOLD: assert property (queue_push && !queue_pop && queue_count == 4'h8 |=>
    queue_count == 4'h8) else $error("overrun moved count");
  AST_UNR_HOLD: assert property (queue_pop && !queue_push && queue_count == 4'h0 |=>
    queue_count == 4'h0) else $error("underrun moved count");
  AST_SOFT_CLR: assert property (datapath_reset |-> ##[0:1] queue_count == 4'h0)
    else $error("soft reset kept count");
  // Track timeout pulses
  AST_STORE_RST: assert property (timeout_store == floor_restore)
    else $error("store and restore differ");
  AST_TO_ON: assert property ((timeout_store & ~track_on) == '0)
    else $error("timeout on disabled track");
  AST_TO_TICK: assert property ((timeout_store & ~sample_tick) == '0)
    else $error("timeout without tick");
  AST_TO_STOP: assert property (timeout_store[0] ##1 !peak_crossing[0] |->
    !timeout_store[0]) else $error("timer not stopped");
  AST_DMA_MIN: assert property (dma_request |-> $past(queue_count) != 4'h0)
    else $error("dma with empty queue");
  COV_TO: cover property (timeout_store[0]);
  COV_DMA: cover property (dma_request);
  COV_SOFT: cover property (datapath_reset);
endmodule // card_reader_control_regs_sva
bind card_reader_control_regs card_reader_control_regs_sva #(.TRACKS(TRACKS)) u_sva (.*);
`default_nettype wire

// ==== test/read_head_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module read_head_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] fire,
  input wire logic [11:0] amp,
  output logic [2:0] sample_tick,
  output logic [2:0] peak_crossing,
  output logic [35:0] peak_amplitude
);
  logic [1:0] div_ff;
  // Ticks every third cycle, held off beside a crossing
  always_ff @(posedge aclk) begin
    div_ff <= (!aresetn || div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
    sample_tick <= (aresetn && div_ff == 2'h2 && fire == 3'h0) ? 3'h7 : 3'h0;
    peak_crossing <= aresetn ? fire : 3'h0;
  end
  // Amplitude valid with a crossing, toggling between them
  always_ff @(posedge aclk) begin
    peak_amplitude <= !aresetn ? '0 : (fire != 3'h0) ? {3{amp}} : ~peak_amplitude;
  end
endmodule // read_head_model
`default_nettype wire

// ==== test/test_card_reader_control_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_card_reader_control_regs;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0, amp = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, aux_sample_new = 1'b0;
  logic queue_push = 1'b0, queue_pop = 1'b0;
  logic [2:0] fire = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdat, v;
  logic [2:0] sample_tick, peak_crossing, track_on, track_raw_sampling_select;
  logic [2:0] timeout_store, floor_restore;
  logic [35:0] peak_amplitude, track_floor_scaled;
  logic converter_bypass, datapath_reset, dma_request, irq, ah, wh, rh, done;
  logic [3:0] queue_count;
  int errors = 0, n_tests = 0, nt = 0, to_ticks = 0, lv, lim;
  card_reader_control_regs u_dut (.*);
  read_head_model u_head (.*);
  initial forever #4 aclk = ~aclk;
  // Ticks on track 0 since its last crossing, sampled mid-cycle
  always @(negedge aclk) begin
    if (peak_crossing[0]) nt <= 0;
    else if (sample_tick[0]) nt <= nt + 1;
    if (timeout_store[0]) to_ticks <= nt + 1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One register write or read; ready is looked at mid-cycle
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(negedge aclk);
      ah = s_axi_awready;
      wh = s_axi_wready;
      rh = s_axi_arready;
      done = w ? s_axi_bvalid : s_axi_rvalid;
      rdat = s_axi_rdata;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (rh) s_axi_arvalid <= 1'b0;
    end while (!done);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic qop(input logic p, input int n);
    @(posedge aclk);
    queue_push <= p;
    queue_pop <= !p;
    repeat (n) @(posedge aclk);
    queue_push <= 1'b0;
    queue_pop <= 1'b0;
    step(3);
  endtask
  function automatic logic [11:0] flr(input logic [11:0] a, input int m);
    return m == 0 ? 12'h0 : 12'(a >> (m + 1));
  endfunction
  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    v = $urandom(99);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 12'(i * 4), '0);
      chk(rdat, i == 2 ? 32'hfff : 32'h0);
    end
    chk(32'(rsp), 32'h2);
    repeat (4) begin
      v = $urandom();
      bus(1'b1, 12'h000, v);
      bus(1'b0, 12'h000, '0);
      chk(rdat, v & 32'h00ff1dff);
      chk(32'({track_raw_sampling_select, converter_bypass, track_on}), 32'({v[12:10], v[15], v[2:0]}));
    end
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 12'h000, 32'h1 | (32'(m) << 7));
      amp <= 12'($urandom());
      fire <= 3'h1;
      @(posedge aclk);
      fire <= 3'h0;
      step(3);
      chk(32'(track_floor_scaled[11:0]), 32'(flr(amp, m)));
    end
    lv = $urandom_range(7, 1);
    bus(1'b1, 12'h000, 32'h00180040 | (32'(lv) << 3));
    qop(1'b1, lv);
    chk(32'({dma_request, queue_count}), 32'(lv));
    qop(1'b1, 9 - lv);
    chk(32'({dma_request, queue_count}), 32'h18);
    bus(1'b0, 12'h004, '0);
    chk(rdat, 32'h00180001);
    chk(32'(irq), 32'h1);
    bus(1'b1, 12'h004, 32'h0);
    bus(1'b0, 12'h004, '0);
    chk(rdat, 32'h00180001);
    bus(1'b1, 12'h004, 32'h00180000);
    bus(1'b0, 12'h004, '0);
    chk(rdat, 32'h00080001);
    qop(1'b0, 9);
    chk(32'({dma_request, queue_count}), 32'h0);
    bus(1'b1, 12'h004, 32'h00080000);
    bus(1'b0, 12'h004, '0);
    chk(rdat, 32'h00200000);
    chk(32'(irq), 32'h0);
    bus(1'b1, 12'h000, 32'h00600000);
    aux_sample_new <= 1'b1;
    @(posedge aclk);
    aux_sample_new <= 1'b0;
    step(3);
    bus(1'b0, 12'h004, '0);
    chk(rdat, 32'h00600001);
    lim = $urandom_range(20, 4);
    bus(1'b1, 12'h000, 32'h00000200);
    bus(1'b1, 12'h008, 32'(lim));
    bus(1'b1, 12'h004, 32'h00ff0000);
    bus(1'b1, 12'h000, 32'h00810003);
    to_ticks = 0;
    fire <= 3'h1;
    @(posedge aclk);
    fire <= 3'h0;
    for (int i = 0; i < 300 && to_ticks == 0; i++) step(1);
    chk(32'(to_ticks), 32'(lim));
    step(3);
    bus(1'b0, 12'h004, '0);
    chk(rdat, 32'h00810001);
    to_ticks = 0;
    step(90);
    chk(32'(to_ticks), 32'h0);
    give_verdict();
  end
endmodule // test_card_reader_control_regs
`default_nettype wire
